// *** occ_pkg.sv ***
// Package: register map, field positions and encodings for the oscillator control unit
package occ_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [11:0] OCC_CLOCK_CONTROL_ADDR = 12'h000;
	localparam logic [11:0] OCC_RC_TRIM_ADDR       = 12'h004;
	localparam logic [11:0] OCC_CONFIG_WORD_ADDR   = 12'h008;

	// ----------------------------------------
	// Unlock keys, one pair per byte
	// ----------------------------------------
	localparam logic [7:0] OCC_LO_KEY1 = 8'h46;
	localparam logic [7:0] OCC_LO_KEY2 = 8'h57;
	localparam logic [7:0] OCC_HI_KEY1 = 8'h78;
	localparam logic [7:0] OCC_HI_KEY2 = 8'h9a;

	// ----------------------------------------
	// Control register field positions
	// ----------------------------------------
	localparam int OCC_CUR_LSB  = 12;
	localparam int OCC_REQ_LSB  = 8;
	localparam int OCC_DIV_LSB  = 6;
	localparam int OCC_LOCK_BIT = 5;
	localparam int OCC_FAIL_BIT = 3;
	localparam int OCC_SOSC_BIT = 1;
	localparam int OCC_SWR_BIT  = 0;

	// ----------------------------------------
	// Configuration word field positions
	// ----------------------------------------
	localparam int OCC_CFG_SWM_LSB  = 14;
	localparam int OCC_CFG_GRP_LSB  = 8;
	localparam int OCC_CFG_MODE_LSB = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] OCC_DIV_RST  = 2'h0;
	localparam logic [3:0] OCC_TRIM_RST = 4'h0;

	// Clock groups
	localparam logic [2:0] OCC_GRP_PLL   = 3'h7;
	localparam logic [2:0] OCC_GRP_EXT   = 3'h3;
	localparam logic [2:0] OCC_GRP_LOW_POWER_RC_OSC  = 3'h2;
	localparam logic [2:0] OCC_GRP_FRC   = 3'h1;
	localparam logic [2:0] OCC_GRP_LPXTL = 3'h0;

	// Unlock tracking per byte
	typedef enum logic [1:0] {
		OCC_LK_IDLE,
		OCC_LK_KEY1,
		OCC_LK_OPEN
	} occ_lock_t;

endpackage

// *** occ_oscillator_control.sv ***
// Oscillator control unit: guarded control register, RC trim and configuration word over APB
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module occ_oscillator_control
	import occ_pkg::*;
(
	input  wire logic        clk_i,            // System clock, 100 MHz
	input  wire logic        rst_i,            // Power-on / brown-out reset, sync, active high
	input  wire logic        psel_i,           // APB select
	input  wire logic        penable_i,        // APB enable
	input  wire logic        pwrite_i,         // APB direction
	input  wire logic [11:0] paddr_i,          // APB byte address
	input  wire logic [31:0] pwdata_i,         // APB write data
	input  wire logic [3:0]  pstrb_i,          // APB byte strobes
	output logic             pready_o,         // APB ready
	output logic [31:0]      prdata_o,         // APB read data
	output logic             pslverr_o,        // APB error, unmapped address
	input  wire logic [23:0] config_word_i,    // Programmed configuration word
	input  wire logic        pll_lock_i,       // PLL lock, async
	input  wire logic        switch_done_i,    // Switch completed, async level
	input  wire logic        clock_fail_i,     // Fail-safe monitor detected failure, async level
	output logic [2:0]       clock_group_o,    // Effective clock group selection
	output logic [4:0]       primary_mode_o,   // Primary group mode select
	output logic [1:0]       clock_divider_sel_o, // Postscaler select
	output logic             switch_req_o,     // Switch request to clock switcher
	output logic             secondary_osc_en_o, // Secondary oscillator enable
	output logic             monitor_en_o,     // Fail-safe monitor enable
	output logic [3:0]       rc_trim_o         // Fast RC trim
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] sync_lvl;
	logic [1:0] evt_prev_ff;

	occ_sync2
	#(
		.WIDTH   (3)
	)
	i_occ_sync2
	(
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({clock_fail_i, switch_done_i, pll_lock_i}),
		.sync_o  (sync_lvl)
	);

	// Edge memory resets to the idle low level, so no false event follows reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			evt_prev_ff <= 2'h0;
		else
			evt_prev_ff <= sync_lvl[2:1];
	end

	wire pll_locked  = sync_lvl[0];
	wire done_rise   = sync_lvl[1] & ~evt_prev_ff[0];
	wire fail_rise   = sync_lvl[2] & ~evt_prev_ff[1];

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	// The word is programmed, not written at run time, so it needs no synchroniser
	wire [1:0] cfg_swm   = config_word_i[OCC_CFG_SWM_LSB +: 2];
	wire [2:0] cfg_group = config_word_i[OCC_CFG_GRP_LSB +: 3];
	wire [4:0] cfg_mode  = config_word_i[OCC_CFG_MODE_LSB +: 5];
	wire       switch_en = ~cfg_swm[1];
	wire       mon_en    = ~cfg_swm[1] & ~cfg_swm[0];
	wire [23:0] cfg_read = {8'h00, cfg_swm, 3'h0, cfg_group, 3'h0, cfg_mode};

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Qualified by ready, so an access phase held longer cannot write twice
	wire access    = psel_i & penable_i & pready_o;
	wire sel_ctl   = paddr_i == OCC_CLOCK_CONTROL_ADDR;
	wire sel_trim  = paddr_i == OCC_RC_TRIM_ADDR;
	wire sel_cfg   = paddr_i == OCC_CONFIG_WORD_ADDR;
	wire mapped    = sel_ctl | sel_trim | sel_cfg;
	wire wr        = access & pwrite_i;
	wire wr_lo     = wr & sel_ctl & pstrb_i[0];
	wire wr_hi     = wr & sel_ctl & pstrb_i[1];
	wire wr_trim   = wr & sel_trim & pstrb_i[0];
	wire [7:0] d_lo = pwdata_i[7:0];
	wire [7:0] d_hi = pwdata_i[15:8];

	// ----------------------------------------
	// Unlock sequencers, one per byte
	// ----------------------------------------
	// A key pair opens the byte for exactly the next write; any other write shuts it.
	logic lo_open;
	logic hi_open;

	occ_unlock_seq
	#(
		.KEY1      (OCC_LO_KEY1),
		.KEY2      (OCC_LO_KEY2)
	)
	i_occ_unlock_lo
	(
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_any_i  (wr),
		.wr_byte_i (wr_lo),
		.data_i    (d_lo),
		.open_o    (lo_open)
	);

	// Own sequencer, so a low-byte pair can never open the high byte
	occ_unlock_seq
	#(
		.KEY1      (OCC_HI_KEY1),
		.KEY2      (OCC_HI_KEY2)
	)
	i_occ_unlock_hi
	(
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_any_i  (wr),
		.wr_byte_i (wr_hi),
		.data_i    (d_hi),
		.open_o    (hi_open)
	);

	wire lo_take = wr_lo & lo_open;
	wire hi_take = wr_hi & hi_open;

	// ----------------------------------------
	// Control register state
	// ----------------------------------------
	logic [2:0] cur_grp_ff;
	logic [2:0] req_grp_ff;
	logic [1:0] div_ff;
	logic       fail_ff;
	logic       sosc_ff;
	logic       swr_ff;
	logic       init_ff;

	// Failure beats completion: the monitor has already moved the clock.
	wire fail_evt = fail_rise & mon_en;
	wire done_evt = done_rise & swr_ff & switch_en & ~fail_evt;

	// With switching off the status field only mirrors the programmed group
	wire [2:0] nxt_cur_grp = ~switch_en ? cfg_group :
		fail_evt ? OCC_GRP_FRC :
		done_evt ? req_grp_ff : cur_grp_ff;
	wire [2:0] nxt_req_grp = hi_take ? d_hi[2:0] : req_grp_ff;
	wire [1:0] nxt_div     = lo_take ? d_lo[OCC_DIV_LSB +: 2] : div_ff;
	// Hardware set wins over a software clear in the same cycle.
	wire       nxt_fail    = fail_evt ? 1'b1 :
		lo_take ? (fail_ff & d_lo[OCC_FAIL_BIT]) : fail_ff;
	wire       nxt_sosc    = lo_take ? d_lo[OCC_SOSC_BIT] : sosc_ff;
	wire       nxt_swr     = (fail_evt | done_evt | ~switch_en) ? 1'b0 :
		lo_take ? d_lo[OCC_SWR_BIT] : swr_ff;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cur_grp_ff <= OCC_GRP_FRC;
			req_grp_ff <= OCC_GRP_FRC;
			div_ff     <= OCC_DIV_RST;
			fail_ff    <= 1'b0;
			sosc_ff    <= 1'b0;
			swr_ff     <= 1'b0;
			init_ff    <= 1'b1;
		end
		else if (init_ff)
		begin
			// Start-up group captured on the first clock after reset release
			cur_grp_ff <= cfg_group;
			req_grp_ff <= cfg_group;
			init_ff    <= 1'b0;
		end
		else
		begin
			cur_grp_ff <= nxt_cur_grp;
			req_grp_ff <= nxt_req_grp;
			div_ff     <= nxt_div;
			fail_ff    <= nxt_fail;
			sosc_ff    <= nxt_sosc;
			swr_ff     <= nxt_swr;
		end
	end

	// ----------------------------------------
	// Trim register
	// ----------------------------------------
	logic [3:0] trim_ff;

	// Not key-guarded: a stray write only nudges the fast RC frequency

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			trim_ff <= OCC_TRIM_RST;
		else if (wr_trim)
			trim_ff <= pwdata_i[3:0];
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire [15:0] ctl_read = {1'b0, cur_grp_ff, 1'b0, req_grp_ff,
		div_ff, pll_locked, 1'b0, fail_ff, 1'b0, sosc_ff, swr_ff};
	wire [31:0] rd_mux = sel_ctl  ? {16'h0000, ctl_read} :
		sel_trim ? {28'h0000000, trim_ff} :
		sel_cfg  ? {8'h00, cfg_read} : 32'h00000000;
	// Reads have no side effects, so the unlock sequencers never see them
	wire        setup  = psel_i & ~penable_i;

	// No wait state: ready is registered from the setup phase and is high in the first access cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h00000000;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o  <= setup;
			prdata_o  <= (setup & ~pwrite_i) ? rd_mux : 32'h00000000;
			pslverr_o <= setup & ~mapped;
		end
	end

	// ----------------------------------------
	// Outputs to the clock tree
	// ----------------------------------------
	// With switching enabled the tree is steered by the requested group, otherwise by the programmed group; the current group is status only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			clock_group_o       <= OCC_GRP_FRC;
			primary_mode_o      <= 5'h00;
			clock_divider_sel_o <= OCC_DIV_RST;
			switch_req_o        <= 1'b0;
			secondary_osc_en_o  <= 1'b0;
			monitor_en_o        <= 1'b0;
			rc_trim_o           <= OCC_TRIM_RST;
		end
		else
		begin
			clock_group_o       <= switch_en ? req_grp_ff : cfg_group;
			primary_mode_o      <= cfg_mode;
			clock_divider_sel_o <= div_ff;
			switch_req_o        <= swr_ff;
			secondary_osc_en_o  <= sosc_ff;
			monitor_en_o        <= mon_en;
			rc_trim_o           <= trim_ff;
		end
	end

endmodule

// ----------------------------------------
// Two-flop synchroniser for levels from another clock domain
// ----------------------------------------
module occ_sync2
#(
	parameter int WIDTH = 1                     // Levels carried
)
(
	input  wire logic             clk_i,        // Destination clock
	input  wire logic             rst_i,        // Sync reset, active high
	input  wire logic [WIDTH-1:0] async_i,      // Levels from another domain
	output logic      [WIDTH-1:0] sync_o        // Levels safe to read on clk_i
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// Only the second stage is read; the first may still be settling
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;

endmodule

// ----------------------------------------
// Key-pair unlock sequencer for one guarded byte
// ----------------------------------------
module occ_unlock_seq
	import occ_pkg::*;
#(
	parameter logic [7:0] KEY1 = 8'h00,         // First key of the pair
	parameter logic [7:0] KEY2 = 8'h00          // Second key of the pair
)
(
	input  wire logic       clk_i,              // System clock
	input  wire logic       rst_i,              // Sync reset, active high
	input  wire logic       wr_any_i,           // Any register write taken this cycle
	input  wire logic       wr_byte_i,          // Write to the guarded byte this cycle
	input  wire logic [7:0] data_i,             // Byte being written
	output logic            open_o              // Next write to the byte lands
);

	occ_lock_t lk_ff;
	occ_lock_t nxt_lk;

	// A repeated first key keeps the sequence armed rather than restarting it
	always_comb
	begin
		nxt_lk = lk_ff;
		if (wr_byte_i)
		begin
			case (lk_ff)
				OCC_LK_IDLE: nxt_lk = (data_i == KEY1) ? OCC_LK_KEY1 : OCC_LK_IDLE;
				OCC_LK_KEY1:
				begin
					if (data_i == KEY2)
						nxt_lk = OCC_LK_OPEN;
					else if (data_i == KEY1)
						nxt_lk = OCC_LK_KEY1;
					else
						nxt_lk = OCC_LK_IDLE;
				end
				OCC_LK_OPEN: nxt_lk = OCC_LK_IDLE;
				default:     nxt_lk = OCC_LK_IDLE;
			endcase
		end
		else if (wr_any_i)
			nxt_lk = OCC_LK_IDLE;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lk_ff <= OCC_LK_IDLE;
		else
			lk_ff <= nxt_lk;
	end

	assign open_o = lk_ff == OCC_LK_OPEN;

endmodule

// *** occ_oscillator_control_props.sv ***
// Checker: port-level properties of the oscillator control unit
`timescale 1ns/1ps
module occ_props
	import occ_pkg::*;
(
	input wire logic        clk_i,          // Clock
	input wire logic        rst_i,          // Reset
	input wire logic        psel_i,         // APB
	input wire logic        penable_i,      // APB
	input wire logic        pwrite_i,       // APB
	input wire logic [11:0] paddr_i,        // APB
	input wire logic [31:0] prdata_o,       // APB
	input wire logic        pready_o,       // APB
	input wire logic        pslverr_o,      // APB
	input wire logic [23:0] config_word_i,  // Config
	input wire logic        pll_lock_i,     // Lock
	input wire logic [2:0]  clock_group_o,  // Group
	input wire logic [4:0]  primary_mode_o, // Mode
	input wire logic        switch_req_o,   // Request
	input wire logic        monitor_en_o    // Monitor
);
	// ----
	// Helpers
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [2:0] lk_cnt_ff;
	logic       lk_last_ff;
	// Lock input is synchronised, so only judge it once it has been still a while
	wire logic [2:0] nxt_lk_cnt = (rst_i || pll_lock_i != lk_last_ff) ? 3'h0 :
		(lk_cnt_ff == 3'h7 ? lk_cnt_ff : lk_cnt_ff + 3'h1);
	wire logic rd_ctl  = pready_o && !pwrite_i && paddr_i == OCC_CLOCK_CONTROL_ADDR;
	wire logic rd_trim = pready_o && !pwrite_i && paddr_i == OCC_RC_TRIM_ADDR;
	wire logic rd_cfg  = pready_o && !pwrite_i && paddr_i == OCC_CONFIG_WORD_ADDR;
	always_ff @(posedge clk_i)
	begin
		lk_last_ff <= pll_lock_i;
		lk_cnt_ff  <= nxt_lk_cnt;
	end
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_cfg_off;
		config_word_i[15] [*3];
	endsequence
	// ----
	// Properties
	// ----
	a_ready_one_cycle: assert property (s_setup |=> pready_o)
		else $error("ready not one cycle after setup");
	a_bad_addr_err: assert property (pready_o && paddr_i[11:4] != 8'h0 |-> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped access not flagged");
	a_ctl_unused_zero: assert property (rd_ctl |-> prdata_o[31:15] == 17'h0 && !prdata_o[11] && !prdata_o[4] && !prdata_o[2])
		else $error("unused control bits not zero");
	a_trim_upper_zero: assert property (rd_trim |-> prdata_o[31:4] == 28'h0)
		else $error("trim upper bits not zero");
	a_cfg_readback: assert property (rd_cfg |-> prdata_o == {8'h0, config_word_i[15:14], 3'h0, config_word_i[10:8], 3'h0, config_word_i[4:0]})
		else $error("config word read wrong");
	a_lock_visible: assert property (rd_ctl && lk_cnt_ff >= 3'h4 |-> prdata_o[OCC_LOCK_BIT] == pll_lock_i)
		else $error("lock bit wrong");
	a_mode_follows: assert property (!$past(rst_i) |-> primary_mode_o == $past(config_word_i[4:0]))
		else $error("primary mode wrong");
	a_monitor_cfg: assert property (!$past(rst_i) |-> monitor_en_o == ($past(config_word_i[15:14]) == 2'h0))
		else $error("monitor enable wrong");
	a_fixed_group: assert property (s_cfg_off |-> clock_group_o == config_word_i[10:8] && !switch_req_o)
		else $error("fixed selection not followed");
endmodule

bind occ_oscillator_control occ_props i_occ_props (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .config_word_i(config_word_i), .pll_lock_i(pll_lock_i), .clock_group_o(clock_group_o),
	.primary_mode_o(primary_mode_o), .switch_req_o(switch_req_o), .monitor_en_o(monitor_en_o));

// *** occ_oscillator_control_tb.sv ***
// Testbench: oscillator control unit against a register model
`timescale 1ns/1ps
module occ_oscillator_control_tb
	import occ_pkg::*;
;
	logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pll_lock_i, switch_done_i, clock_fail_i, perr;
	logic        pready_o, pslverr_o, switch_req_o, secondary_osc_en_o, monitor_en_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rdat, rnd;
	logic [3:0]  pstrb_i, rc_trim_o;
	logic [23:0] cfg;
	logic [2:0]  clock_group_o;
	logic [4:0]  primary_mode_o;
	logic [1:0]  clock_divider_sel_o;
	logic [2:0]  gs [5] = '{OCC_GRP_PLL, OCC_GRP_EXT, OCC_GRP_LOW_POWER_RC_OSC, OCC_GRP_FRC, OCC_GRP_LPXTL};
	int          n_errors, n_tests, cyc, cur, req, dv, fl, so, sw, tr;

	occ_oscillator_control i_occ_oscillator_control (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .config_word_i(cfg),
		.pll_lock_i(pll_lock_i), .switch_done_i(switch_done_i), .clock_fail_i(clock_fail_i),
		.clock_group_o(clock_group_o), .primary_mode_o(primary_mode_o), .clock_divider_sel_o(clock_divider_sel_o),
		.switch_req_o(switch_req_o), .secondary_osc_en_o(secondary_osc_en_o), .monitor_en_o(monitor_en_o),
		.rc_trim_o(rc_trim_o));

	// ----
	// Tasks
	// ----
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic give_verdict();
		$display("errors=%0d checks=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d; pstrb_i <= s;
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		while (pready_o !== 1'b1) @(posedge clk_i);
		rdat = prdata_o;
		perr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic check_all();
		apb(1'b0, OCC_CLOCK_CONTROL_ADDR, 32'h0, 4'h0);
		chk(rdat, {17'h0, 3'(cur), 1'b0, 3'(req), 2'(dv), pll_lock_i, 1'b0, 1'(fl), 1'b0, 1'(so), 1'(sw)});
		chk({19'h0, clock_group_o, clock_divider_sel_o, secondary_osc_en_o, switch_req_o, monitor_en_o, rc_trim_o},
			{19'h0, cfg[15] ? cfg[10:8] : 3'(req), 2'(dv), 1'(so), 1'(sw), cfg[15:14] == 2'h0, 4'(tr)});
	endtask
	task automatic lo(input logic [7:0] v);
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, {24'h0, OCC_LO_KEY1}, 4'h1);
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, {24'h0, OCC_LO_KEY2}, 4'h1);
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, {24'h0, v}, 4'h1);
		dv = v[7:6]; so = v[1]; sw = v[0] & !cfg[15]; fl = fl & v[3];
	endtask
	task automatic hi(input logic [2:0] g);
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, {16'h0, OCC_HI_KEY1, 8'h0}, 4'h2);
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, {16'h0, OCC_HI_KEY2, 8'h0}, 4'h2);
		// Garbage in the read-only bits must not land
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, {16'h0, 5'h1f, g, 8'hff}, 4'h2);
		req = g;
	endtask
	task automatic ev(input bit f);
		if (f) clock_fail_i <= 1'b1; else switch_done_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		clock_fail_i <= 1'b0;
		switch_done_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		if (!f && sw) begin cur = req; sw = 0; end
		if (f && cfg[15:14] == 2'h0) begin cur = OCC_GRP_FRC; fl = 1; sw = 0; end
	endtask
	task automatic rs(input logic [23:0] v);
		cfg <= v;
		rst_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		cur = v[10:8]; req = cur; dv = 0; fl = 0; so = 0; sw = 0; tr = 0;
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000) begin n_errors++; give_verdict(); end
	end

	// ----
	// Scenarios
	// ----
	initial
	begin
		rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; paddr_i = 12'h0; pwdata_i = 32'h0;
		pstrb_i = 4'h0; pll_lock_i = 1'b1; switch_done_i = 1'b0; clock_fail_i = 1'b0; cfg = 24'h0;
		rnd = 32'h62beacb1;
		rnd = xs(rnd);
		// Junk in the reserved configuration bits must never read back
		rs({rnd[23:16], 2'h0, rnd[13:11], OCC_GRP_EXT, rnd[7:5], rnd[4:0]});
		check_all();
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, 32'hffff, 4'h3);
		check_all();
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, {24'h0, OCC_LO_KEY1}, 4'h1);
		apb(1'b1, OCC_RC_TRIM_ADDR, 32'h0, 4'h1);
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, {24'h0, OCC_LO_KEY2}, 4'h1);
		apb(1'b1, OCC_CLOCK_CONTROL_ADDR, 32'hc2, 4'h1);
		check_all();
		for (int i = 0; i < 4; i++)
		begin
			lo(8'(i << 6) | 8'h02);
			apb(1'b1, OCC_CLOCK_CONTROL_ADDR, 32'h0, 4'h1);
			check_all();
		end
		foreach (gs[i])
		begin
			hi(gs[i]);
			lo(8'h01);
			check_all();
			ev(1'b0);
			check_all();
		end
		hi(OCC_GRP_LOW_POWER_RC_OSC);
		lo(8'h01);
		lo(8'h00);
		ev(1'b0);
		check_all();
		lo(8'h01);
		ev(1'b1);
		check_all();
		lo(8'h08);
		check_all();
		lo(8'h00);
		check_all();
		pll_lock_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		check_all();
		rnd = xs(rnd);
		apb(1'b1, OCC_RC_TRIM_ADDR, rnd, 4'hf);
		tr = rnd[3:0];
		apb(1'b0, OCC_RC_TRIM_ADDR, 32'h0, 4'h0);
		chk(rdat, 32'(tr));
		apb(1'b0, 12'h010, 32'h0, 4'h0);
		chk({31'h0, perr}, 32'h1);
		apb(1'b1, OCC_CONFIG_WORD_ADDR, 32'hffffff, 4'hf);
		apb(1'b0, OCC_CONFIG_WORD_ADDR, 32'h0, 4'h0);
		chk(rdat, {8'h0, cfg[15:14], 3'h0, cfg[10:8], 3'h0, cfg[4:0]});
		for (int m = 1; m < 4; m++)
		begin
			rnd = xs(rnd);
			rs({8'h0, 2'(m), 3'h0, OCC_GRP_PLL, 3'h0, rnd[4:0]});
			lo(8'h01);
			ev(1'b1);
			check_all();
		end
		give_verdict();
	end
endmodule
